// *** core_model.sv ***
// Purpose: behavioural stand-in for the core fed by the reset controller
// Assumes: reset strobes are active high, run_enable gates stepping
// Notes:   program counter only; enough to see where execution restarts
`timescale 1ns/10ps
module core_model (
    input  wire logic aclk,
    input  wire logic core_reset,
    input  wire logic pc_sp_clear,
    input  wire logic run_enable,
    output logic [7:0] pc
);
    // pc cleared by either strobe, else it steps while the core may run
    always_ff @(posedge aclk) begin
        if (core_reset || pc_sp_clear) begin
            pc <= 8'h00;
        end else if (run_enable) begin
            pc <= pc + 8'h01;
        end
    end
endmodule

// *** rst_init_ctrl.sv ***
// Purpose: merges power-on, under-voltage and watchdog resets for a small core
// Assumes: status inputs are pins and pass two flip-flops; core pulses are local
// Notes:   drives reset strobes, core defaults and cause flags
// Functional notes
// - power-on clears program counter to zero
// - power-on sets port data, direction all ones
// - hold reset for power-on delay
// - under-voltage monitor on outside power-down, sets cause flag
// - short low-supply glitches are ignored
// - four valid threshold codes, lowest to highest
// - invalid code resets, restores power-on value
// - invalid code sets bit 1, software clears
// - valid low-voltage resets, register kept
// - under-voltage reset disabled in power-down
// - under-voltage flag bit 2, software clears
// - normal watchdog timeout: full reset, timeout set
// - sleep watchdog: clear pc, sp only, set timeout and powerdown
// - oscillator start-up wait per clock source
// - timeout/powerdown flags per reset kind
// - interrupts off, timers off, stack top
// - watchdog and time base cleared, restart
// - threshold register powers on at 0x55
// - powerdown flag: clear at power-up/clear, set halt
`timescale 1ns/10ps
module rst_init_ctrl #(
    parameter int por_cycles   = rst_init_pkg::por_delay_cyc,
    parameter int uv_qual_cyc  = 8
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        sub_clock,
    input  wire logic        low_supply,
    input  wire logic        wdt_timeout,
    input  wire logic        halt_exec,
    input  wire logic        wdt_clear,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             core_reset,
    output logic             pc_sp_clear,
    output logic             ports_preset,
    output logic             periph_reset,
    output logic             wdt_restart,
    output logic [1:0]       threshold_level,
    output logic             run_enable
);
    import rst_init_pkg::*;

    // two-stage synchronisers for pin inputs
    logic [1:0] sub_sync_reg, lows_sync_reg;
    logic       sub_prev_reg;    // last synchronised sub clock level
    logic       sub_tick;        // one pulse per sub clock rising edge
    // registers
    logic [7:0] threshold_reg;   // low_voltage_threshold_select_reg
    logic [3:0] mode_flags_reg;  // cause flags, bits 3..0
    logic       sys_keep_reg;    // idle_system_clock_keep
    logic       timeout_reg;     // timeout_status_flag
    logic       powerdown_reg;   // powerdown_status_flag
    logic       pwr_down_reg;    // device in power-down mode
    logic [2:0] osc_sel_reg;     // current system clock source
    // sequencing
    seq_state_type state_reg;
    logic [31:0]   cnt_reg;      // delay counter
    logic [15:0]   uv_cnt_reg;   // low-supply qualify counter
    logic          uv_qual_reg;  // qualified low-supply indication
    logic          uv_fire, inv_fire;
    logic          code_bad;
    logic          wd_normal, wd_sleep;

    // valid code check and level decode
    function automatic logic code_valid(input logic [7:0] c);
        code_valid = (c == code_lv0) || (c == code_lv1) || (c == code_lv2) || (c == code_lv3);
    endfunction
    function automatic logic [1:0] code_level(input logic [7:0] c);
        case (c)
            code_lv1: code_level = 2'h1;
            code_lv2: code_level = 2'h2;
            code_lv3: code_level = 2'h3;
            default:  code_level = 2'h0;
        endcase
    endfunction
    function automatic logic [31:0] sst_len(input logic [2:0] s);
        case (s)
            osc_fast_xt, osc_slow_xt: sst_len = 32'(sst_xtal_cyc);
            osc_slow_rc:              sst_len = 32'(sst_slow_cyc);
            default:                  sst_len = 32'(sst_rc_cyc);
        endcase
    endfunction

    // synchronise pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sub_sync_reg  <= 2'h0;
            lows_sync_reg <= 2'h0;
            sub_prev_reg  <= 1'b0;
        end else begin
            sub_sync_reg  <= {sub_sync_reg[0], sub_clock};
            lows_sync_reg <= {lows_sync_reg[0], low_supply};
            sub_prev_reg  <= sub_sync_reg[1];
        end
    end
    assign sub_tick = sub_sync_reg[1] && !sub_prev_reg;

    // qualify low supply: must persist longer than the qualify time
    always_ff @(posedge aclk) begin
        if (!aresetn || !lows_sync_reg[1] || pwr_down_reg) begin
            uv_cnt_reg  <= 16'h0;
            uv_qual_reg <= 1'b0;
        end else if (uv_cnt_reg != 16'(uv_qual_cyc)) begin
            uv_cnt_reg <= uv_cnt_reg + 16'h1;
        end else begin
            uv_qual_reg <= 1'b1;
        end
    end

    assign code_bad  = !code_valid(threshold_reg);
    assign wd_normal = wdt_timeout && (state_reg == st_run) && !pwr_down_reg;
    assign wd_sleep  = wdt_timeout && (state_reg == st_run) && pwr_down_reg;

    // sub clock timers for the under-voltage and invalid-code reset requests
    sub_req_timer uv_timer (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .sub_tick (sub_tick),
        .req      (uv_qual_reg && state_reg == st_run),
        .fire     (uv_fire)
    );
    sub_req_timer inv_timer (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .sub_tick (sub_tick),
        .req      (code_bad && state_reg == st_run),
        .fire     (inv_fire)
    );

    // reset sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg    <= st_por;
            cnt_reg      <= 32'h0;
            core_reset   <= 1'b1;
            pc_sp_clear  <= 1'b1;
            ports_preset <= 1'b1;
            periph_reset <= 1'b1;
            wdt_restart  <= 1'b1;
            run_enable   <= 1'b0;
        end else begin
            pc_sp_clear <= 1'b0;
            wdt_restart <= 1'b0;
            case (state_reg)
                st_por: begin
                    if (cnt_reg >= 32'(por_cycles - 1)) begin
                        state_reg <= st_sst;
                        cnt_reg   <= 32'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                st_run: begin
                    if (uv_fire || inv_fire || wd_normal) begin
                        state_reg    <= st_reset;
                        run_enable   <= 1'b0;
                        core_reset   <= 1'b1;
                        pc_sp_clear  <= 1'b1;
                        ports_preset <= 1'b1;
                        periph_reset <= 1'b1;
                        wdt_restart  <= 1'b1;
                        cnt_reg      <= 32'h0;
                    end else if (wd_sleep) begin
                        state_reg   <= st_sst;
                        run_enable  <= 1'b0;
                        pc_sp_clear <= 1'b1;
                        cnt_reg     <= 32'h0;
                    end
                end
                st_reset: begin
                    if (cnt_reg >= 32'(por_cycles - 1)) begin
                        state_reg <= st_sst;
                        cnt_reg   <= 32'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                st_sst: begin
                    if (cnt_reg >= sst_len(osc_sel_reg) - 32'h1) begin
                        state_reg    <= st_run;
                        run_enable   <= 1'b1;
                        core_reset   <= 1'b0;
                        ports_preset <= 1'b0;
                        periph_reset <= 1'b0;
                        cnt_reg      <= 32'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 32'h1;
                    end
                end
                default: state_reg <= st_por;
            endcase
        end
    end

    // axi write channel capture
    logic        aw_hold_reg, w_hold_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_go;
    assign wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    // accept address and data in either order, answer after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h0;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= resp_okay;
        end else begin
            s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg <= off_control && aw_addr_reg[1:0] == 2'h0)
                                ? resp_okay : resp_slverr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_lane0;
    assign wr_lane0 = wr_go && w_strb_reg[0];

    // threshold select register; restored only on invalid code reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            threshold_reg <= threshold_por;
        end else if (inv_fire) begin
            threshold_reg <= threshold_por;
        end else if (wr_lane0 && aw_addr_reg == off_threshold_sel) begin
            threshold_reg <= w_data_reg[7:0];
        end
    end

    // cause flags: hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_flags_reg <= 4'h0;
            sys_keep_reg   <= 1'b0;
        end else begin
            if (wr_lane0 && aw_addr_reg == off_mode_one) begin
                mode_flags_reg <= mode_flags_reg & w_data_reg[3:0];
                sys_keep_reg   <= w_data_reg[bit_sys_keep];
            end
            if (uv_fire) begin
                mode_flags_reg[bit_uv_flag] <= 1'b1;
            end
            if (inv_fire) begin
                mode_flags_reg[bit_inval_flag] <= 1'b1;
            end
        end
    end

    // timeout and powerdown flags; power-down mode and clock source control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_reg   <= 1'b0;
            powerdown_reg <= 1'b0;
            pwr_down_reg  <= 1'b0;
            osc_sel_reg   <= osc_fast_rc;
        end else begin
            if (wr_lane0 && aw_addr_reg == off_control) begin
                osc_sel_reg <= w_data_reg[3:1];
            end
            if (wd_normal) begin
                timeout_reg <= 1'b1;
            end else if (wd_sleep) begin
                timeout_reg   <= 1'b1;
                powerdown_reg <= 1'b1;
                pwr_down_reg  <= 1'b0;
            end else if (halt_exec && state_reg == st_run) begin
                powerdown_reg <= 1'b1;
                pwr_down_reg  <= 1'b1;
            end else if (wdt_clear) begin
                powerdown_reg <= 1'b0;
                timeout_reg   <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= resp_okay;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= resp_okay;
                case (s_axi_araddr[7:0])
                    off_threshold_sel: s_axi_rdata <= {24'h0, threshold_reg};
                    off_mode_one:  s_axi_rdata <= {24'h0, sys_keep_reg, 3'h0, mode_flags_reg};
                    off_status:    s_axi_rdata <= {30'h0, timeout_reg, powerdown_reg};
                    off_control:   s_axi_rdata <= {28'h0, osc_sel_reg, pwr_down_reg};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= resp_slverr;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // threshold level to the analogue comparator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            threshold_level <= 2'h0;
        end else begin
            threshold_level <= code_level(threshold_reg);
        end
    end

    // checks
    inval_restore_a: assert property (@(posedge aclk) disable iff (!aresetn)
        inv_fire |=> threshold_reg == threshold_por && mode_flags_reg[bit_inval_flag])
        else $error("invalid code not restored");
    uv_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        uv_fire |=> mode_flags_reg[bit_uv_flag] && core_reset)
        else $error("under-voltage flag missing");
    wd_norm_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_normal |=> timeout_reg && core_reset && pc_sp_clear)
        else $error("normal watchdog reset wrong");
    wd_sleep_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wd_sleep |=> timeout_reg && powerdown_reg && !core_reset && pc_sp_clear)
        else $error("sleep watchdog reset wrong");
    pd_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pwr_down_reg |=> !uv_qual_reg)
        else $error("under-voltage active in power-down");
    halt_pd_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (halt_exec && state_reg == st_run && !wdt_timeout) |=> powerdown_reg)
        else $error("halt did not set powerdown");
    run_ports_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !run_enable |-> ports_preset || state_reg == st_sst || state_reg == st_run)
        else $error("ports released early");
    level_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (threshold_reg == code_lv3) |=> threshold_level == 2'h3)
        else $error("threshold level decode wrong");
    cov_uv_c:    cover property (@(posedge aclk) uv_fire);
    cov_inv_c:   cover property (@(posedge aclk) inv_fire);
    cov_sleep_c: cover property (@(posedge aclk) wd_sleep);
endmodule

// *** rst_init_pkg.sv ***
// Purpose: shared constants for the reset and initialisation controller
// Assumes: 25 MHz aclk, AXI4-Lite register access, byte offsets below
// Notes:   sub clock ticks arrive as a pin-level square wave
package rst_init_pkg;
    // register byte offsets
    localparam logic [7:0] off_threshold_sel = 8'h00;  // low_voltage_threshold_select_reg
    localparam logic [7:0] off_mode_one      = 8'h04;  // system_mode_register_one
    localparam logic [7:0] off_status        = 8'h08;  // timeout and powerdown flags
    localparam logic [7:0] off_control       = 8'h0c;  // power-down and osc select
    // threshold codes, lowest to highest trip
    localparam logic [7:0] code_lv0 = 8'h55;
    localparam logic [7:0] code_lv1 = 8'h33;
    localparam logic [7:0] code_lv2 = 8'h99;
    localparam logic [7:0] code_lv3 = 8'haa;
    localparam logic [7:0] threshold_por = 8'h55;
    // system mode register one bit positions
    localparam int bit_wdt_flag   = 0;
    localparam int bit_inval_flag = 1;
    localparam int bit_uv_flag    = 2;
    localparam int bit_rst_flag   = 3;
    localparam int bit_sys_keep   = 7;
    // status register bit positions
    localparam int bit_powerdown  = 0;
    localparam int bit_timeout    = 1;
    // port register reset values
    localparam logic [7:0] port_por = 8'hff;
    // power-on delay and its cycle count at 25 MHz
    localparam int clk_mhz        = 25;
    localparam int por_delay_ms   = 50;
    localparam int por_delay_cyc  = por_delay_ms * 1000 * clk_mhz;
    // oscillator start-up waits in source clocks (upper figure of each range)
    localparam int sst_rc_cyc     = 16;
    localparam int sst_xtal_cyc   = 1024;
    localparam int sst_slow_cyc   = 2;
    // oscillator source encodings
    localparam logic [2:0] osc_fast_rc  = 3'h0;
    localparam logic [2:0] osc_ext_rc   = 3'h1;
    localparam logic [2:0] osc_fast_xt  = 3'h2;
    localparam logic [2:0] osc_slow_xt  = 3'h3;
    localparam logic [2:0] osc_slow_rc  = 3'h4;
    // sub clock edges to reset after a qualified request
    localparam logic [1:0] sub_req_lat  = 2'h2;
    // axi responses
    localparam logic [1:0] resp_okay    = 2'h0;
    localparam logic [1:0] resp_slverr  = 2'h2;
    // state machine
    typedef enum logic [1:0] {
        st_por   = 2'b00,
        st_run   = 2'b01,
        st_reset = 2'b10,
        st_sst   = 2'b11
    } seq_state_type;
endpackage

// *** sub_req_timer.sv ***
// Purpose: counts sub clock edges for a pending reset request
// Assumes: sub_tick is a one-cycle pulse per sub clock rising edge
// Notes:   fires after two sub clock edges, so one to two sub periods
`timescale 1ns/10ps
module sub_req_timer (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic sub_tick,
    input  wire logic req,
    output logic      fire
);
    import rst_init_pkg::*;
    logic [1:0] cnt_reg;  // sub edges seen while request stands
    // count sub edges while the request holds; drop back when it goes away
    always_ff @(posedge aclk) begin
        if (!aresetn || !req) begin
            cnt_reg <= 2'h0;
            fire    <= 1'b0;
        end else begin
            fire <= 1'b0;
            if (sub_tick && cnt_reg != sub_req_lat) begin
                cnt_reg <= cnt_reg + 2'h1;
                if (cnt_reg + 2'h1 == sub_req_lat) begin
                    fire <= 1'b1;
                end
            end
        end
    end
endmodule

// *** testbench.sv ***
// Purpose: directed checks of the reset and initialisation controller
// Assumes: power-on delay shortened to 20 cycles, sub clock 8 aclk periods
// Notes:   registers reached over AXI4-Lite, output waits sampled on falling edge, register reads on rising edge
`timescale 1ns/10ps
module testbench;
    import rst_init_pkg::*;
    logic aclk, aresetn, low_supply, wdt_timeout, halt_exec, wdt_clear;
    logic sub_clock = 1'b0;  // driven only by the sub clock process below
    logic [31:0] awaddr, wdata, araddr, rdata, d;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp, tl, br;  // br: last response code taken by a task
    logic core_reset, pc_sp_clear, ports_preset, periph_reset, wdt_restart, run_enable;
    logic [7:0] pc;
    logic [7:0] codes [4] = '{code_lv0, code_lv1, code_lv2, code_lv3};
    int n_fail = 0, n_compared = 0, cyc = 0;
    initial begin
        aclk = 0;
        forever #20 aclk = ~aclk;
    end
    rst_init_ctrl #(.por_cycles(20), .uv_qual_cyc(8)) dut (.aclk(aclk), .aresetn(aresetn),
        .sub_clock(sub_clock), .low_supply(low_supply), .wdt_timeout(wdt_timeout),
        .halt_exec(halt_exec), .wdt_clear(wdt_clear), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
        .ports_preset(ports_preset), .periph_reset(periph_reset),
        .wdt_restart(wdt_restart), .threshold_level(tl), .run_enable(run_enable));
    core_model partner (.aclk(aclk), .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
        .run_enable(run_enable), .pc(pc));
    // free-running sub clock and the hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) begin
            sub_clock <= ~sub_clock;
        end
        if (cyc == 30000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one write; address and data offered together, held until taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        br = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [1:0] r;
        rd(a, d, r);
        chk(d & m, e);
    endtask
    // wait, bounded, until a selected output takes a value
    task automatic wt(input int s, input logic v, input int lim);
        logic x;
        for (int k = 0; k < lim; k++) begin
            @(negedge aclk);
            x = (s == 0) ? core_reset : (s == 1) ? run_enable : pc_sp_clear;
            if (x === v) break;
        end
        chk(x, v);
    endtask
    task automatic boot();
        wt(0, 1'b0, 400);
        wt(1, 1'b1, 400);
    endtask
    // no core reset seen for n cycles
    task automatic quiet(input int n);
        logic f = 1'b0;
        repeat (n) begin
            @(negedge aclk);
            f |= core_reset;
        end
        chk(f, 1'b0);
    endtask
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        {aresetn, low_supply, wdt_timeout, halt_exec, wdt_clear} = '0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, araddr} = '0;
        repeat (20) @(posedge aclk);
        @(negedge aclk);
        chk({core_reset, ports_preset, periph_reset, wdt_restart, run_enable}, 5'h1e);
        chk(pc, 8'h00);
        @(posedge aclk) aresetn <= 1'b1;
        boot();
        rc(off_threshold_sel, 32'hff, threshold_por);
        rc(off_status, 32'h3, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(off_threshold_sel, {24'h0, codes[i]});
            rc(off_threshold_sel, 32'hff, codes[i]);
            chk(tl, i);
        end
        wr(off_mode_one, 32'h0);
        // short low-supply glitch, then a long one
        low_supply <= 1'b1;
        repeat (3) @(posedge aclk);
        low_supply <= 1'b0;
        quiet(60);
        @(posedge aclk) low_supply <= 1'b1;
        wt(0, 1'b1, 80);
        @(posedge aclk) low_supply <= 1'b0;
        boot();
        rc(off_threshold_sel, 32'hff, code_lv3);
        rc(off_mode_one, 32'hf, 32'h4);
        wr(off_mode_one, 32'h0);
        rc(off_mode_one, 32'hf, 32'h0);
        // power-down: monitor off, watchdog wake clears pc only
        @(posedge aclk) halt_exec <= 1'b1;
        @(posedge aclk) halt_exec <= 1'b0;
        rc(off_control, 32'h1, 32'h1);
        low_supply <= 1'b1;
        quiet(60);
        @(posedge aclk) low_supply <= 1'b0;
        repeat (8) @(posedge aclk);
        wdt_timeout <= 1'b1;
        @(posedge aclk) wdt_timeout <= 1'b0;
        wt(2, 1'b1, 20);
        // pc clears at the edge after the strobe is seen
        @(negedge aclk);
        chk({core_reset, pc}, 9'h0);
        wt(1, 1'b1, 100);
        rc(off_status, 32'h3, 32'h3);
        rc(off_threshold_sel, 32'hff, code_lv3);
        @(posedge aclk) wdt_clear <= 1'b1;
        @(posedge aclk) wdt_clear <= 1'b0;
        rc(off_status, 32'h3, 32'h0);
        // invalid threshold code
        wr(off_threshold_sel, 32'h12);
        wt(0, 1'b1, 60);
        boot();
        rc(off_threshold_sel, 32'hff, threshold_por);
        rc(off_mode_one, 32'hf, 32'h2);
        // watchdog overflow while running, slow rc start-up wait
        wr(off_control, {28'h0, osc_slow_rc, 1'b0});
        @(posedge aclk) wdt_timeout <= 1'b1;
        @(posedge aclk) wdt_timeout <= 1'b0;
        wt(0, 1'b1, 20);
        chk({core_reset, pc_sp_clear, ports_preset, periph_reset, wdt_restart}, 5'h1f);
        // 20 reset cycles then the slow rc wait before running again
        repeat (19 + sst_slow_cyc) @(negedge aclk);
        chk(run_enable, 1'b0);
        @(negedge aclk);
        chk(run_enable, 1'b1);
        rc(off_status, 32'h3, 32'h2);
        // unmapped offset refused on both channels
        wr(8'h10, 32'h0);
        chk({30'h0, br}, {30'h0, resp_slverr});
        rd(8'h10, d, br);
        chk(d, 32'h0);
        chk({30'h0, br}, {30'h0, resp_slverr});
        end_of_test();
    end
endmodule
